// [src/epa_pkg.sv]
`default_nettype none
package epa_pkg;
	// Term layout: index = energy type * phases + phase
	localparam int N_OUT = 4;
	localparam int N_PH = 3;
	localparam int N_TERM = 18;
	localparam int TERM_IDX_W = 5;
	localparam int INT_W = 42;
	localparam int EUSR_W = 45;
	localparam int PUSR_W = 32;
	localparam int LO_W = 13;
	localparam int PACC_W = 40;
	localparam int TMR_W = 25;
	localparam int IVL_W = 13;
	localparam int DIV_W = 16;
	localparam int LT_W = 20;

	// Energy type codes, also the type part of a term index
	localparam logic [2:0] SEL_TOTAL_WATT = 3'h0;
	localparam logic [2:0] SEL_TOTAL_VAR = 3'h1;
	localparam logic [2:0] SEL_TOTAL_VA = 3'h2;
	localparam logic [2:0] SEL_FUND_WATT = 3'h3;
	localparam logic [2:0] SEL_FUND_VAR = 3'h4;
	localparam logic [2:0] SEL_FUND_VA = 3'h5;
	localparam logic [2:0] MASK_ALL_PHASES = 3'h7;
	localparam int SIGN_SRC_ACT_BIT = 0;
	localparam int SIGN_SRC_REACT_BIT = 1;

	// Converter scaling: rate / (512 * sample rate) gives gain per sample
	localparam longint CONV_RATE_HZ = 4096000;
	localparam longint SAMPLE_RATE_HZ = 8000;
	localparam longint CONV_SCALE = 512;
	localparam int POWER_GAIN = int'(CONV_RATE_HZ / (CONV_SCALE * SAMPLE_RATE_HZ));

	// Timing
	localparam longint CLK_HZ = 200000000;
	localparam longint CLK_PERIOD_NS = 5;
	localparam longint MASTER_CLK_HZ = 25000000;
	localparam longint WIDTH_TICK_MASTER_CLOCK_IN = 6;
	localparam int WIDTH_TICK_CYC = int'((WIDTH_TICK_MASTER_CLOCK_IN * CLK_HZ) / MASTER_CLK_HZ);
	localparam longint FIXED_WIDTH_NS = 80000000;
	localparam int FIXED_WIDTH_CYC = int'((FIXED_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// Host programming limits and recommendations
	localparam logic [LT_W-1:0] WIDTH_COUNT_MAX = 20'h50000;
	localparam logic [31:0] THRESHOLD_RECOMMENDED = 32'h0010_0000;
	localparam logic [DIV_W-1:0] DIVIDER_MIN = 16'h0002;

	// Term memory word: {energy int, energy user, power int, power user}
	localparam int P_USR_LSB = 0;
	localparam int P_INT_LSB = P_USR_LSB + PUSR_W;
	localparam int E_USR_LSB = P_INT_LSB + INT_W;
	localparam int E_INT_LSB = E_USR_LSB + EUSR_W;
	localparam int MEM_W = E_INT_LSB + INT_W;

	typedef enum logic [2:0] {
		ST_INIT,
		ST_IDLE,
		ST_RD,
		ST_WR,
		ST_HOST_WAIT,
		ST_HOST_CAP
	} epa_state_e;
endpackage
`default_nettype wire

// [src/epa_term_ram.sv]
`default_nettype none
module epa_term_ram #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 18,
	parameter int AW = 5
) (
	// Clock
	input wire logic clk,
	// Write side
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	// Read side
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] rd_data_q;

	// Contents are zeroed by the owner after reset
	always_ff @(posedge clk)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
		rd_data_q <= mem[rd_addr];
	end

	assign rd_data = rd_data_q;
endmodule // epa_term_ram
`default_nettype wire

// [src/epa_metering.sv]
`default_nettype none
module epa_metering
	import epa_pkg::*;
#(
	parameter int unsigned FIXED_WIDTH_CYCLES = epa_pkg::FIXED_WIDTH_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Processing-rate data
	input wire logic sample_strobe,
	input wire logic half_cycle_strobe,
	input wire logic [epa_pkg::N_TERM-1:0][31:0] power_in,
	input wire logic [epa_pkg::N_TERM-1:0] no_load,
	// Accumulation control
	input wire logic metering_enable,
	input wire logic energy_load_mode,
	input wire logic energy_timer_select,
	input wire logic [epa_pkg::IVL_W-1:0] energy_interval,
	input wire logic [epa_pkg::IVL_W-1:0] power_interval,
	input wire logic [1:0] power_sign_source,
	// Pulse control
	input wire logic [epa_pkg::N_OUT-1:0][2:0] pulse_energy_select,
	input wire logic [epa_pkg::N_OUT-1:0][2:0] pulse_phase_mask,
	input wire logic [31:0] pulse_threshold,
	input wire logic [epa_pkg::N_OUT-1:0][epa_pkg::DIV_W-1:0] pulse_divider,
	input wire logic [epa_pkg::N_OUT-1:0] pulse_width_mode,
	input wire logic [epa_pkg::LT_W-1:0] pulse_width_count,
	input wire logic [epa_pkg::N_OUT-1:0] pulse_output_disable,
	input wire logic pulse_accum_clear,
	input wire logic status_clear,
	// Result read port
	input wire logic read_request,
	input wire logic [epa_pkg::TERM_IDX_W-1:0] read_index,
	output logic read_valid,
	output logic [31:0] energy_high_word,
	output logic [epa_pkg::LO_W-1:0] energy_low_word,
	output logic [31:0] power_accum_word,
	// Pulse pins and status
	output logic [epa_pkg::N_OUT-1:0] pulse_output_pin,
	output logic [epa_pkg::N_OUT-1:0] pulse_energy_sign,
	output logic [epa_pkg::N_OUT-1:0] pulse_sign_change,
	output logic [epa_pkg::N_OUT-1:0] pulse_ready,
	output logic [5:0] phase_sign_flags,
	output logic [2:0] active_power_reversed,
	output logic [2:0] reactive_power_reversed,
	output logic energy_ready,
	output logic power_ready
);
	import epa_pkg::*;

	typedef struct packed {
		epa_state_e st;
		logic [TERM_IDX_W-1:0] addr;
		logic [IVL_W-1:0] egy_cnt;
		logic [IVL_W-1:0] pwr_cnt;
		logic egy_due;
		logic egy_evt;
		logic pwr_evt;
		logic rd_pend;
		logic [TERM_IDX_W-1:0] rd_idx;
		logic [N_OUT-1:0][PACC_W-1:0] acc;
		logic [N_OUT-1:0][DIV_W-1:0] div;
		logic [N_OUT-1:0][TMR_W-1:0] tmr;
		logic [N_OUT-1:0] pin;
		logic [N_OUT-1:0] has;
		logic [N_OUT-1:0] sign;
		logic [N_OUT-1:0] sign_chg;
		logic [N_OUT-1:0] pready;
		logic [5:0] ph_sign;
		logic [2:0] rev_act;
		logic [2:0] rev_react;
		logic egy_rdy;
		logic pwr_rdy;
		logic rd_valid;
		logic [31:0] hi;
		logic [LO_W-1:0] lo;
		logic [31:0] pword;
	} epa_core_s;

	localparam epa_core_s CORE_RESET = '{st: ST_INIT, pin: '1, default: '0};

	epa_core_s q;
	epa_core_s d;
	logic mem_we;
	logic [MEM_W-1:0] mem_wdata;
	logic [MEM_W-1:0] mem_rdata;
	logic [N_OUT-1:0] pevt;
	logic [N_OUT-1:0] psign;
	logic [N_OUT-1:0] nl_out;
	logic [PACC_W-1:0] thr_ext;
	logic [PACC_W-1:0] add;
	logic cross_p;
	logic cross_n;
	logic [DIV_W-1:0] div_nx;
	logic [DIV_W-1:0] half;
	logic [TMR_W-1:0] tmr_nx;
	logic [TMR_W-1:0] lt_cyc;
	logic [INT_W-1:0] v;
	logic [INT_W-1:0] e_new;
	logic [INT_W-1:0] p_new;
	logic [EUSR_W-1:0] e_usr;
	logic [PUSR_W-1:0] p_usr;

	function automatic logic [PACC_W-1:0] sext_pacc(input logic [31:0] x);
		return {{(PACC_W-32){x[31]}}, x};
	endfunction

	// Sum of the selected type over masked phases, terms in no-load count zero
	function automatic logic [PACC_W-1:0] term_sum(input logic [N_TERM-1:0][31:0] p,
			input logic [N_TERM-1:0] nl, input logic [2:0] sel, input logic [2:0] mask);
		logic [PACC_W-1:0] s;
		int idx;
		s = '0;
		for (int ph = 0; ph < N_PH; ph++)
		begin
			idx = int'(sel) * N_PH + ph;
			if (sel <= SEL_FUND_VA && mask[ph] && !nl[idx])
				s = s + sext_pacc(p[idx]);
		end
		return s;
	endfunction

	function automatic logic terms_noload(input logic [N_TERM-1:0] nl,
			input logic [2:0] sel, input logic [2:0] mask);
		logic r;
		r = 1'b1;
		for (int ph = 0; ph < N_PH; ph++)
			if (sel <= SEL_FUND_VA && mask[ph] && !nl[int'(sel) * N_PH + ph])
				r = 1'b0;
		return r;
	endfunction

	function automatic logic [TERM_IDX_W-1:0] sign_term(input logic fund,
			input logic [2:0] total_sel, input logic [2:0] fund_sel, input int ph);
		return TERM_IDX_W'(int'(fund ? fund_sel : total_sel) * N_PH + ph);
	endfunction

	epa_term_ram #(.WIDTH(MEM_W), .DEPTH(N_TERM), .AW(TERM_IDX_W)) u_ram (
		.clk(clk),
		.wr_en(mem_we),
		.wr_addr(q.addr),
		.wr_data(mem_wdata),
		.rd_addr(q.addr),
		.rd_data(mem_rdata)
	);

	always_comb
	begin
		d = q;
		mem_we = 1'b0;
		mem_wdata = '0;
		pevt = '0;
		psign = '0;
		nl_out = '0;
		add = '0;
		cross_p = 1'b0;
		cross_n = 1'b0;
		div_nx = '0;
		half = '0;
		tmr_nx = '0;
		v = '0;
		e_new = '0;
		p_new = '0;
		e_usr = mem_rdata[E_USR_LSB +: EUSR_W];
		p_usr = mem_rdata[P_USR_LSB +: PUSR_W];
		d.egy_rdy = 1'b0;
		d.pwr_rdy = 1'b0;
		d.rd_valid = 1'b0;
		thr_ext = {{(PACC_W-32){1'b0}}, pulse_threshold};
		lt_cyc = TMR_W'(pulse_width_count * WIDTH_TICK_CYC);
		if (status_clear)
		begin
			d.sign_chg = '0;
			d.pready = '0;
			d.rev_act = '0;
			d.rev_react = '0;
		end
		// Converter gains by whole units per sample, so no fractional step
		for (int k = 0; k < N_OUT; k++)
		begin
			nl_out[k] = terms_noload(no_load, pulse_energy_select[k], pulse_phase_mask[k]);
			add = '0;
			if (sample_strobe && metering_enable)
				add = PACC_W'(term_sum(power_in, no_load, pulse_energy_select[k],
					pulse_phase_mask[k]) * POWER_GAIN);
			cross_p = $signed(q.acc[k]) >= $signed(thr_ext);
			cross_n = $signed(q.acc[k]) <= -$signed(thr_ext);
			// One crossing per clock; far faster than any legal pulse rate
			d.acc[k] = q.acc[k] + add - (cross_p ? thr_ext : '0) + (cross_n ? thr_ext : '0);
			div_nx = q.div[k] + 16'h1;
			half = DIV_W'((17'(pulse_divider[k]) + 17'h1) >> 1);
			pevt[k] = (cross_p || cross_n) && div_nx >= pulse_divider[k];
			psign[k] = cross_n;
			if (cross_p || cross_n)
				d.div[k] = pevt[k] ? '0 : div_nx;
			tmr_nx = q.tmr[k] + 25'h1;
			if (!q.pin[k])
			begin
				d.tmr[k] = tmr_nx;
				if (!pulse_width_mode[k])
				begin
					// No-load stops crossings, so the timer alone finishes the pulse
					if (tmr_nx >= TMR_W'(FIXED_WIDTH_CYCLES)
							|| ((cross_p || cross_n) && !pevt[k] && div_nx == half))
						d.pin[k] = 1'b1;
				end
				else if (tmr_nx >= lt_cyc && !nl_out[k])
					d.pin[k] = 1'b1;
			end
			if (pevt[k])
			begin
				d.sign[k] = cross_n;
				if (q.has[k] && q.sign[k] != cross_n)
					d.sign_chg[k] = 1'b1;
				d.has[k] = 1'b1;
				if (!pulse_output_disable[k])
				begin
					d.pready[k] = 1'b1;
					d.pin[k] = 1'b0;
					d.tmr[k] = '0;
				end
			end
			if (pulse_output_disable[k])
				d.pin[k] = 1'b1;
			if (pulse_accum_clear)
			begin
				d.acc[k] = '0;
				d.div[k] = '0;
			end
		end
		case (q.st)
			ST_INIT:
			begin
				mem_we = 1'b1;
				d.addr = q.addr + 5'h1;
				if (q.addr == TERM_IDX_W'(N_TERM - 1))
				begin
					d.addr = '0;
					d.st = ST_IDLE;
				end
			end
			ST_IDLE:
			begin
				if (sample_strobe)
				begin
					d.st = ST_RD;
					d.addr = '0;
					d.pwr_evt = q.pwr_cnt == power_interval;
					d.pwr_cnt = d.pwr_evt ? '0 : q.pwr_cnt + 13'h1;
					if (!energy_timer_select)
					begin
						d.egy_evt = q.egy_cnt == energy_interval;
						d.egy_cnt = d.egy_evt ? '0 : q.egy_cnt + 13'h1;
					end
					else
					begin
						d.egy_evt = q.egy_due;
						d.egy_due = 1'b0;
					end
				end
				else if (q.rd_pend)
				begin
					d.addr = q.rd_idx;
					d.rd_pend = 1'b0;
					d.st = ST_HOST_WAIT;
				end
			end
			ST_RD:
				d.st = ST_WR;
			ST_WR:
			begin
				v = {{(INT_W-32){power_in[q.addr][31]}}, power_in[q.addr]};
				e_new = mem_rdata[E_INT_LSB +: INT_W];
				p_new = mem_rdata[P_INT_LSB +: INT_W] + (metering_enable ? v : '0);
				if (metering_enable && !no_load[q.addr])
					e_new = e_new + v;
				if (q.egy_evt)
				begin
					if (energy_load_mode)
						e_usr = {{(EUSR_W-INT_W){e_new[INT_W-1]}}, e_new};
					else
						e_usr = e_usr + {{(EUSR_W-INT_W){e_new[INT_W-1]}}, e_new};
					e_new = '0;
				end
				if (q.pwr_evt)
				begin
					p_usr = p_new[INT_W-1 -: PUSR_W];
					for (int ph = 0; ph < N_PH; ph++)
					begin
						if (q.addr == sign_term(power_sign_source[SIGN_SRC_ACT_BIT],
								SEL_TOTAL_WATT, SEL_FUND_WATT, ph))
						begin
							if (p_new[INT_W-1] != q.ph_sign[2*ph])
								d.rev_act[ph] = 1'b1;
							d.ph_sign[2*ph] = p_new[INT_W-1];
						end
						if (q.addr == sign_term(power_sign_source[SIGN_SRC_REACT_BIT],
								SEL_TOTAL_VAR, SEL_FUND_VAR, ph))
						begin
							if (p_new[INT_W-1] != q.ph_sign[2*ph+1])
								d.rev_react[ph] = 1'b1;
							d.ph_sign[2*ph+1] = p_new[INT_W-1];
						end
					end
					p_new = '0;
				end
				mem_we = 1'b1;
				mem_wdata = {e_new, e_usr, p_new, p_usr};
				d.addr = q.addr + 5'h1;
				d.st = ST_RD;
				if (q.addr == TERM_IDX_W'(N_TERM - 1))
				begin
					d.st = ST_IDLE;
					d.egy_rdy = q.egy_evt;
					d.pwr_rdy = q.pwr_evt;
				end
			end
			ST_HOST_WAIT:
				d.st = ST_HOST_CAP;
			ST_HOST_CAP:
			begin
				d.hi = e_usr[EUSR_W-1 -: 32];
				d.lo = e_usr[LO_W-1:0];
				d.pword = p_usr;
				d.rd_valid = 1'b1;
				d.st = ST_IDLE;
			end
			default:
				d.st = ST_IDLE;
		endcase
		// Half-cycle tick is remembered until the next sample walk
		if (energy_timer_select && half_cycle_strobe)
		begin
			d.egy_cnt = (q.egy_cnt == energy_interval) ? '0 : q.egy_cnt + 13'h1;
			if (q.egy_cnt == energy_interval)
				d.egy_due = 1'b1;
		end
		if (read_request)
		begin
			d.rd_pend = 1'b1;
			d.rd_idx = read_index;
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			q <= CORE_RESET;
		else
			q <= d;
	end

	assign pulse_output_pin = q.pin;
	assign pulse_energy_sign = q.sign;
	assign pulse_sign_change = q.sign_chg;
	assign pulse_ready = q.pready;
	assign phase_sign_flags = q.ph_sign;
	assign active_power_reversed = q.rev_act;
	assign reactive_power_reversed = q.rev_react;
	assign energy_ready = q.egy_rdy;
	assign power_ready = q.pwr_rdy;
	assign read_valid = q.rd_valid;
	assign energy_high_word = q.hi;
	assign energy_low_word = q.lo;
	assign power_accum_word = q.pword;

	a_disable_high: assert property (@(posedge clk) disable iff (!reset_n)
		pulse_output_disable[0] |=> pulse_output_pin[0])
		else $error("disabled pulse output not high");
	a_clear_empties: assert property (@(posedge clk) disable iff (!reset_n)
		pulse_accum_clear |=> q.acc[0] == '0 && q.div[0] == '0)
		else $error("accumulator clear did not empty converter");
	a_pulse_starts_low: assert property (@(posedge clk) disable iff (!reset_n)
		pevt[0] && !pulse_output_disable[0] |=> !pulse_output_pin[0] && pulse_ready[0])
		else $error("pulse event did not drive output low");
	a_pulse_sign_kept: assert property (@(posedge clk) disable iff (!reset_n)
		pevt[0] |=> pulse_energy_sign[0] == $past(psign[0]))
		else $error("pulse sign flag wrong");
	a_sign_change_set: assert property (@(posedge clk) disable iff (!reset_n)
		pevt[0] && q.has[0] && psign[0] != q.sign[0] |=> pulse_sign_change[0])
		else $error("sign change flag not set");
	a_noload_hold: assert property (@(posedge clk) disable iff (!reset_n)
		!pulse_output_pin[0] && pulse_width_mode[0] && nl_out[0] && !pulse_output_disable[0]
		|=> !pulse_output_pin[0])
		else $error("mode one output released during no-load");
	a_half_duty_end: assert property (@(posedge clk) disable iff (!reset_n)
		!q.pin[0] && !pulse_width_mode[0] && !pevt[0]
		&& ($signed(q.acc[0]) >= $signed(thr_ext) || $signed(q.acc[0]) <= -$signed(thr_ext))
		&& q.div[0] + 16'h1 == DIV_W'((17'(pulse_divider[0]) + 17'h1) >> 1)
		|=> pulse_output_pin[0])
		else $error("mode zero pulse did not end at half count");
	a_power_ready_time: assert property (@(posedge clk) disable iff (!reset_n)
		q.st == ST_IDLE && sample_strobe && q.pwr_cnt == power_interval
		|-> ##[36:40] power_ready)
		else $error("power ready missing after interval");
	a_rev_sticky: assert property (@(posedge clk) disable iff (!reset_n)
		active_power_reversed[0] && !status_clear |=> active_power_reversed[0])
		else $error("reversal flag lost without clear");
	a_energy_overwrite: assert property (@(posedge clk) disable iff (!reset_n)
		q.st == ST_WR && q.egy_evt |-> mem_wdata[E_INT_LSB +: INT_W] == '0)
		else $error("internal energy not restarted at energy ready");
endmodule // epa_metering
`default_nettype wire

// [verification/epa_meter_model.sv]
`default_nettype none
// Meter-side pulse counter: counts low pulses and keeps the last low width
module epa_meter_model
	import epa_pkg::*;
(
	// Clock
	input wire logic clk,
	// Pulse pins and count reset
	input wire logic [epa_pkg::N_OUT-1:0] pin,
	input wire logic zero_counts,
	// Results
	output int pulses [epa_pkg::N_OUT],
	output int width [epa_pkg::N_OUT]
);
	timeunit 1ns;
	timeprecision 100ps;
	int run [N_OUT];

	// Widths are in clk cycles, so the pin is sampled on the same edge as the design
	always @(posedge clk)
	begin
		for (int i = 0; i < N_OUT; i++)
		begin
			if (pin[i] === 1'b0)
			begin
				run[i] <= run[i] + 1;
				if (run[i] == 0)
					pulses[i] <= pulses[i] + 1;
			end
			else
			begin
				if (run[i] != 0)
					width[i] <= run[i];
				run[i] <= 0;
			end
			if (zero_counts)
				pulses[i] <= 0;
		end
	end
endmodule // epa_meter_model
`default_nettype wire

// [verification/energy_pulse_and_power_accumulation_tb_top.sv]
`default_nettype none
module energy_pulse_and_power_accumulation_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import epa_pkg::*;
	localparam int FIX_W = 200;
	logic clk, reset_n, sample_strobe, half_cycle_strobe, zero_counts;
	logic [N_TERM-1:0][31:0] power_in;
	logic [N_TERM-1:0] no_load;
	logic metering_enable, energy_load_mode, energy_timer_select;
	logic [IVL_W-1:0] energy_interval, power_interval;
	logic [1:0] power_sign_source;
	logic [N_OUT-1:0][2:0] pulse_energy_select, pulse_phase_mask;
	logic [31:0] pulse_threshold, energy_high_word, power_accum_word;
	logic [N_OUT-1:0][DIV_W-1:0] pulse_divider;
	logic [N_OUT-1:0] pulse_width_mode, pulse_output_disable, pulse_output_pin;
	logic [N_OUT-1:0] pulse_energy_sign, pulse_sign_change, pulse_ready;
	logic [LT_W-1:0] pulse_width_count;
	logic pulse_accum_clear, status_clear, read_request, read_valid, energy_ready, power_ready;
	logic [TERM_IDX_W-1:0] read_index;
	logic [LO_W-1:0] energy_low_word;
	logic [5:0] phase_sign_flags;
	logic [2:0] active_power_reversed, reactive_power_reversed;
	int fails, samples_checked, n_egy, n_pwr;
	int pulses [N_OUT];
	int width [N_OUT];

	epa_metering #(.FIXED_WIDTH_CYCLES(FIX_W)) epa_metering_i (
		.clk, .reset_n, .sample_strobe, .half_cycle_strobe, .power_in, .no_load,
		.metering_enable, .energy_load_mode, .energy_timer_select, .energy_interval,
		.power_interval, .power_sign_source, .pulse_energy_select, .pulse_phase_mask,
		.pulse_threshold, .pulse_divider, .pulse_width_mode, .pulse_width_count,
		.pulse_output_disable, .pulse_accum_clear, .status_clear, .read_request,
		.read_index, .read_valid, .energy_high_word, .energy_low_word, .power_accum_word,
		.pulse_output_pin, .pulse_energy_sign, .pulse_sign_change, .pulse_ready,
		.phase_sign_flags, .active_power_reversed, .reactive_power_reversed,
		.energy_ready, .power_ready
	);

	epa_meter_model epa_meter_model_i (
		.clk, .pin(pulse_output_pin), .zero_counts, .pulses, .width
	);

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk)
	begin
		if (energy_ready === 1'b1)
			n_egy++;
		if (power_ready === 1'b1)
			n_pwr++;
	end

	task automatic finish_test();
		$display("checks %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic ck(input string what, input logic [63:0] exp, input logic [63:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
			fails++;
		end
	endtask

	task automatic hang(input string what);
		$display("mismatch %s expected event seen timeout", what);
		fails++;
		finish_test();
	endtask

	task automatic strobe(input int gap);
		@(negedge clk);
		sample_strobe = 1'b1;
		@(negedge clk);
		sample_strobe = 1'b0;
		repeat (gap) @(negedge clk);
	endtask

	task automatic walks(input int n, input int gap);
		repeat (n) strobe(gap);
	endtask

	task automatic pulse_ctl(input logic acc);
		@(negedge clk);
		pulse_accum_clear = acc;
		status_clear = 1'b1;
		zero_counts = 1'b1;
		@(negedge clk);
		pulse_accum_clear = 1'b0;
		status_clear = 1'b0;
		zero_counts = 1'b0;
	endtask

	// Extra cycle at the end lets the meter model record the width
	task automatic wait_pin(input int i, input logic lvl, input int bound);
		int k = 0;
		while (pulse_output_pin[i] !== lvl && k < bound)
		begin
			@(negedge clk);
			k++;
		end
		if (pulse_output_pin[i] !== lvl)
			hang("pulse pin level");
		@(negedge clk);
	endtask

	task automatic rd(input int idx);
		int k = 0;
		@(negedge clk);
		read_request = 1'b1;
		read_index = TERM_IDX_W'(idx);
		@(negedge clk);
		read_request = 1'b0;
		while (read_valid !== 1'b1 && k < 10)
		begin
			@(negedge clk);
			k++;
		end
		if (read_valid !== 1'b1)
			hang("read valid");
	endtask

	task automatic do_reset();
		reset_n = 1'b0;
		repeat (5) @(negedge clk);
		ck("reset pins high", 4'hf, pulse_output_pin);
		reset_n = 1'b1;
		repeat (25) @(negedge clk);
	endtask

	initial
	begin
		{sample_strobe, half_cycle_strobe, zero_counts, read_request} = '0;
		{pulse_accum_clear, status_clear, read_index} = '0;
		{power_in, no_load, power_sign_source, pulse_energy_select} = '0;
		{fails, samples_checked, n_egy, n_pwr} = '0;
		reset_n = 1'b0;
		metering_enable = 1'b1;
		energy_load_mode = 1'b1;
		energy_timer_select = 1'b0;
		energy_interval = 13'h3;
		power_interval = 13'h3;
		pulse_phase_mask = 12'h249;
		// Small threshold keeps pulse counts short; the usual value is far larger
		pulse_threshold = 32'h400;
		pulse_divider = {4{DIVIDER_MIN}};
		pulse_width_mode = 4'hf;
		pulse_width_count = 20'h3;
		pulse_output_disable = 4'h0;
		do_reset();

		power_in[0] = 32'h400;
		walks(4, 60);
		ck("energy ready count", 1, n_egy);
		ck("power ready count", 1, n_pwr);
		rd(0);
		ck("energy high", 0, energy_high_word);
		ck("energy low", 13'h1000, energy_low_word);
		ck("power word", 4, power_accum_word);
		energy_load_mode = 1'b0;
		walks(4, 60);
		rd(0);
		ck("energy high sum", 1, energy_high_word);
		ck("energy low sum", 0, energy_low_word);
		energy_timer_select = 1'b1;
		energy_interval = 13'h1;
		n_egy = 0;
		repeat (4)
		begin
			@(negedge clk);
			half_cycle_strobe = 1'b1;
			@(negedge clk);
			half_cycle_strobe = 1'b0;
			strobe(60);
		end
		ck("half cycle ready count", 2, n_egy);
		n_egy = 0;
		walks(3, 60);
		ck("ready without half cycles", 0, n_egy);
		energy_timer_select = 1'b0;
		$display("test accumulation done");

		pulse_phase_mask = {3'h7, 3'h7, 3'h5, 3'h2};
		for (int c = 0; c < 6; c++)
		begin
			power_in = '0;
			power_in[c * N_PH + 1] = 32'h400;
			pulse_energy_select = {3'(c), 3'((c + 1) % 6), 3'(c), 3'(c)};
			pulse_ctl(1'b1);
			walks(2, 200);
			ck("out0 pulses", 1, pulses[0]);
			ck("out1 masked phase", 0, pulses[1]);
			ck("out2 other type", 0, pulses[2]);
			ck("out3 all phases", 1, pulses[3]);
			ck("out0 width", 3 * WIDTH_TICK_CYC, width[0]);
			ck("pins idle", 4'hf, pulse_output_pin);
		end
		$display("test select and mask done");

		power_in = '0;
		pulse_energy_select = '0;
		pulse_phase_mask = 12'h249;
		pulse_threshold = THRESHOLD_RECOMMENDED;
		power_in[0] = THRESHOLD_RECOMMENDED;
		pulse_ctl(1'b1);
		walks(2, 200);
		ck("recommended threshold", 1, pulses[0]);
		pulse_threshold = 32'h400;
		power_in[0] = 32'h400;
		pulse_ctl(1'b1);
		walks(4, 200);
		ck("pulse rate", 2, pulses[0]);
		ck("sign positive", 0, pulse_energy_sign[0]);
		ck("no sign change", 0, pulse_sign_change[0]);
		ck("ready set", 1, pulse_ready[0]);
		power_in[0] = 32'hffff_fc00;
		walks(2, 200);
		ck("sign negative", 1, pulse_energy_sign[0]);
		ck("sign change", 1, pulse_sign_change[0]);
		pulse_output_disable = 4'h1;
		power_in[0] = 32'h400;
		pulse_ctl(1'b0);
		walks(2, 200);
		ck("disabled pulses", 0, pulses[0]);
		ck("disabled ready", 0, pulse_ready[0]);
		ck("disabled change kept", 1, pulse_sign_change[0]);
		ck("other ready", 1, pulse_ready[1]);
		pulse_output_disable = 4'h0;
		pulse_ctl(1'b1);
		strobe(200);
		pulse_ctl(1'b1);
		strobe(200);
		ck("cleared no pulse", 0, pulses[0]);
		strobe(200);
		ck("pulse after clear", 1, pulses[0]);
		$display("test sign disable clear done");

		pulse_width_mode = 4'h0;
		pulse_ctl(1'b1);
		walks(2, 300);
		ck("fixed width", FIX_W, width[0]);
		// Strobes 42 cycles apart, divider two: half of an 84-cycle period
		pulse_ctl(1'b1);
		walks(3, 40);
		ck("half duty width", 42, width[0]);
		pulse_ctl(1'b1);
		strobe(300);
		strobe(0);
		wait_pin(0, 1'b0, 60);
		no_load = '1;
		wait_pin(0, 1'b1, 300);
		ck("no-load completes pulse", FIX_W, width[0]);
		pulse_ctl(1'b1);
		walks(2, 300);
		ck("no-load no pulses", 0, pulses[0]);
		no_load = '0;
		pulse_width_mode = 4'hf;
		pulse_width_count = 20'h1;
		pulse_ctl(1'b1);
		strobe(100);
		strobe(0);
		wait_pin(0, 1'b0, 60);
		no_load = '1;
		repeat (100) @(negedge clk);
		ck("held low in no-load", 0, pulse_output_pin[0]);
		no_load = '0;
		wait_pin(0, 1'b1, 60);
		$display("test width and no-load done");

		power_interval = 13'h0;
		power_in = '0;
		power_in[0] = 32'h400;
		power_in[9] = 32'h400;
		power_in[3] = 32'h400;
		power_in[12] = 32'hffff_fc00;
		do_reset();
		strobe(60);
		ck("watt sign", 0, phase_sign_flags[0]);
		ck("var sign total", 0, phase_sign_flags[1]);
		ck("no active reversal", 0, active_power_reversed[0]);
		power_in[0] = 32'hffff_fc00;
		strobe(60);
		ck("watt sign negative", 1, phase_sign_flags[0]);
		ck("active reversal", 1, active_power_reversed[0]);
		ck("no reactive reversal", 0, reactive_power_reversed[0]);
		power_sign_source = 2'h3;
		strobe(60);
		ck("fund watt sign", 0, phase_sign_flags[0]);
		ck("fund var sign", 1, phase_sign_flags[1]);
		$display("test power sign done");
		finish_test();
	end
endmodule // energy_pulse_and_power_accumulation_tb_top
`default_nettype wire
